// *** src/obcd_pkg.sv ***
// obcd_pkg: shared constants for the option byte configuration decoder
package obcd_pkg;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] OBCD_ADDR_STARTUP = 8'h00; // startup_config_byte
  localparam logic [7:0] OBCD_ADDR_PROTECT = 8'h04; // memory_protect_config_byte
  localparam logic [7:0] OBCD_ADDR_CTRL = 8'h08; // command register
  localparam logic [7:0] OBCD_ADDR_STATUS = 8'h0C; // status register

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int OBCD_CLK_HI = 7; // startup_clock_select
  localparam int OBCD_CLK_LO = 6;
  localparam int OBCD_UV_HI = 3; // undervoltage_threshold_select
  localparam int OBCD_UV_LO = 2;
  localparam int OBCD_WDG_TYPE = 1; // watchdog_type_select
  localparam int OBCD_WDG_HALT = 0; // watchdog reset on halt
  localparam int OBCD_SEC_HI = 3; // sector_zero_size
  localparam int OBCD_SEC_LO = 2;
  localparam int OBCD_READOUT = 1; // readout_protect
  localparam int OBCD_WLOCK = 0; // flash_write_lock
  localparam int OBCD_CTRL_ERASE = 0; // erase command bit
  localparam int OBCD_ST_PROG = 0; // status: programming mode
  localparam int OBCD_ST_BUSY = 1; // status: erase running
  localparam int OBCD_ST_REFUSED = 2; // status: sticky refused access
  localparam int OBCD_ST_CAPT = 3; // status: settings captured

  // ************************************************************
  // reset / erased values and encodings
  // ************************************************************
  localparam logic [7:0] OBCD_STARTUP_DEFAULT = 8'h2F;
  localparam logic [7:0] OBCD_PROTECT_DEFAULT = 8'hF0;
  localparam logic [1:0] OBCD_CLK_INT_RC = 2'h0;
  localparam logic [1:0] OBCD_CLK_WAKE_RC = 2'h1;
  localparam logic [1:0] OBCD_CLK_EXT = 2'h3;
  localparam logic [1:0] OBCD_UV_OFF = 2'h3;
  localparam logic [1:0] OBCD_SECT_0K5 = 2'h0;
  localparam logic [1:0] OBCD_SECT_1K = 2'h1;
  localparam logic [1:0] OBCD_SECT_2K = 2'h2;

  // ************************************************************
  // axi response codes
  // ************************************************************
  localparam logic [1:0] OBCD_RESP_OKAY = 2'h0;
  localparam logic [1:0] OBCD_RESP_SLVERR = 2'h2;
  localparam logic [1:0] OBCD_RESP_DECERR = 2'h3;

  // erase sequencer states
  typedef enum logic [0:0] {OBCD_IDLE, OBCD_MEM_ERASE} obcd_state_t;

endpackage

// *** src/obcd_dec_if.sv ***
// obcd_dec_if: decoded option settings passed from decoder to top
`timescale 1ns/10ps
`default_nettype none

interface obcd_dec_if;
  logic clk_internal_rc;
  logic clk_wakeup_rc;
  logic clk_external;
  logic uv_enable;
  logic [1:0] uv_level;
  logic wdg_hw_enable;
  logic wdg_halt_reset;
  logic [1:0] sector_size;
  logic readout_protect;
  logic flash_write_lock;

  // ************************************************************
  // producer and consumer views
  // ************************************************************
  modport dec (output clk_internal_rc, clk_wakeup_rc, clk_external, uv_enable, uv_level,
               wdg_hw_enable, wdg_halt_reset, sector_size, readout_protect, flash_write_lock);
  modport sink (input clk_internal_rc, clk_wakeup_rc, clk_external, uv_enable, uv_level,
               wdg_hw_enable, wdg_halt_reset, sector_size, readout_protect, flash_write_lock);
endinterface

`default_nettype wire

// *** src/obcd_decode.sv ***
// obcd_decode: combinational decode of the two option bytes
`timescale 1ns/10ps
`default_nettype none

module obcd_decode
  import obcd_pkg::*;
(
  input wire logic [7:0] startup_byte, // startup_config_byte content
  input wire logic [7:0] protect_byte, // memory_protect_config_byte content
  obcd_dec_if.dec d // decoded settings
);

  // ************************************************************
  // clock source; reserved code falls back to internal rc
  // ************************************************************
  wire logic [1:0] clk_field = startup_byte[OBCD_CLK_HI:OBCD_CLK_LO];
  assign d.clk_wakeup_rc = (clk_field == OBCD_CLK_WAKE_RC);
  assign d.clk_external = (clk_field == OBCD_CLK_EXT);
  assign d.clk_internal_rc = !d.clk_wakeup_rc && !d.clk_external;

  // detector: 11 off, else code is level (0 low, 1 mid, 2 high)
  wire logic [1:0] uv_field = startup_byte[OBCD_UV_HI:OBCD_UV_LO];
  assign d.uv_enable = (uv_field != OBCD_UV_OFF);
  assign d.uv_level = d.uv_enable ? uv_field : 2'h0;

  // watchdog options
  assign d.wdg_hw_enable = !startup_byte[OBCD_WDG_TYPE];
  assign d.wdg_halt_reset = startup_byte[OBCD_WDG_HALT];

  // sector 0 size: low bit set wins
  assign d.sector_size = protect_byte[OBCD_SEC_LO] ? OBCD_SECT_2K :
                         (protect_byte[OBCD_SEC_HI] ? OBCD_SECT_1K : OBCD_SECT_0K5);

  // memory protection
  assign d.readout_protect = protect_byte[OBCD_READOUT];
  assign d.flash_write_lock = protect_byte[OBCD_WLOCK];

endmodule

`default_nettype wire

// *** src/obcd_top.sv ***
// obcd_top: option byte store, axi4-lite access and reset-time settings capture
// Summary of operation
// - clock field picks internal, wakeup, reserved, external
// - default clock field starts internal rc oscillator
// - detector field: low, medium, high threshold, off
// - watchdog type: zero hardware, one software
// - halt entry resets when watchdog halt bit set
// - sector zero size 0.5K, 1K or 2K
// - readout protection blocks extraction and flash writes
// - erase under readout protection erases memory first
// - write lock freezes memory and option bytes forever
// - option bytes accessible only in programming mode
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none

module obcd_top
  import obcd_pkg::*;
#(
  parameter int ADDR_W = 8 // axi address width
)(
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic prog_mode, // device in programming mode
  input wire logic mem_erase_done, // program memory erase finished
  output logic mem_erase_req, // program memory erase request
  output logic clk_sel_internal_rc, // start from internal rc
  output logic clk_sel_wakeup_rc, // start from wakeup_rc_oscillator
  output logic clk_sel_external, // start from external_clock_pin
  output logic undervoltage_detector_en, // undervoltage_detector enabled
  output logic [1:0] undervoltage_level, // 0 low, 1 medium, 2 high
  output logic wdg_hw_enable, // watchdog forced on in hardware
  output logic wdg_halt_reset, // reset on halt entry
  output logic [1:0] sector_zero_size, // 0 half k, 1 one k, 2 two k
  output logic flash_read_block, // block memory extraction
  output logic flash_write_block, // refuse flash writes
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read response valid
  input wire logic s_axi_rready // read response ready
);

  // ************************************************************
  // state
  // ************************************************************
  logic [7:0] startup_q = OBCD_STARTUP_DEFAULT; // erased content at power-up
  logic [7:0] protect_q = OBCD_PROTECT_DEFAULT;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic refused_q, captured_q, erase_req_q;
  obcd_state_t state_q;
  logic clk_int_q, clk_wake_q, clk_ext_q, uv_en_q, wdg_hw_q, wdg_halt_q, rd_blk_q, wr_blk_q;
  logic [1:0] uv_lvl_q, sect_q;

  obcd_dec_if dec_bus();

  // decode of the stored bytes
  obcd_decode u_decode (
    .startup_byte(startup_q),
    .protect_byte(protect_q),
    .d(dec_bus)
  );

  // ************************************************************
  // write channel decode
  // ************************************************************
  wire logic aw_hs = s_axi_awvalid && awready_q;
  wire logic w_hs = s_axi_wvalid && wready_q;
  wire logic b_hs = bvalid_q && s_axi_bready;
  wire logic wr_go = !awready_q && !wready_q && !bvalid_q;
  wire logic idle = (state_q == OBCD_IDLE);
  wire logic wa_startup = (awaddr_q[7:0] == OBCD_ADDR_STARTUP);
  wire logic wa_protect = (awaddr_q[7:0] == OBCD_ADDR_PROTECT);
  wire logic wa_ctrl = (awaddr_q[7:0] == OBCD_ADDR_CTRL);
  wire logic wa_status = (awaddr_q[7:0] == OBCD_ADDR_STATUS);
  wire logic wa_mapped = wa_startup || wa_protect || wa_ctrl || wa_status;
  // byte store open only in programming mode, unlocked, no erase running
  wire logic store_open = prog_mode && !protect_q[OBCD_WLOCK] && idle;
  wire logic wr_cfg = wr_go && (wa_startup || wa_protect) && wstrb_q[0];
  wire logic wr_startup_ok = wr_go && wa_startup && wstrb_q[0] && store_open;
  wire logic wr_protect_ok = wr_go && wa_protect && wstrb_q[0] && store_open;
  wire logic erase_cmd = wr_go && wa_ctrl && wstrb_q[0] && wdata_q[OBCD_CTRL_ERASE];
  wire logic erase_start = erase_cmd && store_open;
  wire logic wr_refused = (wr_cfg && !store_open) || (erase_cmd && !store_open);
  wire logic clr_refused = wr_go && wa_status && wstrb_q[0] && wdata_q[OBCD_ST_REFUSED];
  wire logic [1:0] wr_resp = !wa_mapped ? OBCD_RESP_DECERR :
                             (wr_refused ? OBCD_RESP_SLVERR : OBCD_RESP_OKAY);

  // ************************************************************
  // erase sequencing and byte store next values
  // ************************************************************
  wire logic erase_now = erase_start && !protect_q[OBCD_READOUT];
  wire logic erase_mem_first = erase_start && protect_q[OBCD_READOUT];
  wire logic mem_done = (state_q == OBCD_MEM_ERASE) && mem_erase_done;
  wire logic restore = erase_now || mem_done;
  wire logic [7:0] startup_d = restore ? OBCD_STARTUP_DEFAULT : (wr_startup_ok ? wdata_q[7:0] : startup_q);
  wire logic [7:0] protect_d = restore ? OBCD_PROTECT_DEFAULT : (wr_protect_ok ? wdata_q[7:0] : protect_q);
  wire logic refused_d = wr_refused || (refused_q && !clr_refused);

  // ************************************************************
  // read channel decode
  // ************************************************************
  wire logic ar_hs = s_axi_arvalid && arready_q;
  wire logic r_hs = rvalid_q && s_axi_rready;
  wire logic ra_startup = (s_axi_araddr[7:0] == OBCD_ADDR_STARTUP);
  wire logic ra_protect = (s_axi_araddr[7:0] == OBCD_ADDR_PROTECT);
  wire logic ra_ctrl = (s_axi_araddr[7:0] == OBCD_ADDR_CTRL);
  wire logic ra_status = (s_axi_araddr[7:0] == OBCD_ADDR_STATUS);
  wire logic ra_cfg_bad = (ra_startup || ra_protect) && !prog_mode;
  wire logic [31:0] status_word = {28'h0000000, captured_q, refused_q, !idle, prog_mode};
  wire logic [31:0] rd_data = ra_cfg_bad ? 32'h00000000 :
                              ra_startup ? {24'h000000, startup_q} :
                              ra_protect ? {24'h000000, protect_q} :
                              ra_status ? status_word : 32'h00000000;
  wire logic [1:0] rd_resp = !(ra_startup || ra_protect || ra_ctrl || ra_status) ? OBCD_RESP_DECERR :
                             (ra_cfg_bad ? OBCD_RESP_SLVERR : OBCD_RESP_OKAY);

  // write address and data capture, response after both
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= OBCD_RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_hs) begin
        awready_q <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_resp;
      end
      if (b_hs) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // read answer registered on the same edge that takes the address
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= OBCD_RESP_OKAY;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_data;
      rresp_q <= rd_resp;
    end else if (r_hs) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // option byte store: no reset, bytes survive reset like nonvolatile cells
  always_ff @(posedge sys_clk) begin
    startup_q <= startup_d;
    protect_q <= protect_d;
  end

  // refused flag (set beats clear)
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      refused_q <= 1'b0;
    end else begin
      refused_q <= refused_d;
    end
  end

  // erase sequencer: memory erase handshake before byte restore
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= OBCD_IDLE;
      erase_req_q <= 1'b0;
    end else begin
      case (state_q)
        OBCD_IDLE: begin
          if (erase_mem_first) begin
            state_q <= OBCD_MEM_ERASE;
            erase_req_q <= 1'b1;
          end
        end
        OBCD_MEM_ERASE: begin
          if (mem_erase_done) begin
            state_q <= OBCD_IDLE;
            erase_req_q <= 1'b0;
          end
        end
        default: begin
          state_q <= OBCD_IDLE;
          erase_req_q <= 1'b0;
        end
      endcase
    end
  end

  // capture decoded settings once after reset release, then hold
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      captured_q <= 1'b0;
      clk_int_q <= 1'b1;
      clk_wake_q <= 1'b0;
      clk_ext_q <= 1'b0;
      uv_en_q <= 1'b0;
      uv_lvl_q <= 2'h0;
      wdg_hw_q <= 1'b0;
      wdg_halt_q <= 1'b0;
      sect_q <= OBCD_SECT_0K5;
      rd_blk_q <= 1'b0;
      wr_blk_q <= 1'b0;
    end else if (!captured_q) begin
      captured_q <= 1'b1;
      clk_int_q <= dec_bus.clk_internal_rc;
      clk_wake_q <= dec_bus.clk_wakeup_rc;
      clk_ext_q <= dec_bus.clk_external;
      uv_en_q <= dec_bus.uv_enable;
      uv_lvl_q <= dec_bus.uv_level;
      wdg_hw_q <= dec_bus.wdg_hw_enable;
      wdg_halt_q <= dec_bus.wdg_halt_reset;
      sect_q <= dec_bus.sector_size;
      rd_blk_q <= dec_bus.readout_protect;
      wr_blk_q <= dec_bus.readout_protect || dec_bus.flash_write_lock;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign mem_erase_req = erase_req_q;
  assign clk_sel_internal_rc = clk_int_q;
  assign clk_sel_wakeup_rc = clk_wake_q;
  assign clk_sel_external = clk_ext_q;
  assign undervoltage_detector_en = uv_en_q;
  assign undervoltage_level = uv_lvl_q;
  assign wdg_hw_enable = wdg_hw_q;
  assign wdg_halt_reset = wdg_halt_q;
  assign sector_zero_size = sect_q;
  assign flash_read_block = rd_blk_q;
  assign flash_write_block = wr_blk_q;

  // ************************************************************
  // checks
  // ************************************************************
  AST_CLK_SOURCE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(captured_q) |-> (clk_ext_q == ($past(startup_q[OBCD_CLK_HI:OBCD_CLK_LO]) == 2'h3))
      && (clk_wake_q == ($past(startup_q[OBCD_CLK_HI:OBCD_CLK_LO]) == 2'h1)))
    else $error("clock source select mismatch");
  AST_CLK_DEFAULT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(captured_q) && ($past(startup_q[OBCD_CLK_HI:OBCD_CLK_LO]) == 2'h0) |-> clk_int_q && !clk_ext_q)
    else $error("default clock is not internal rc");
  AST_UV_SELECT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(captured_q) |-> (uv_en_q == ($past(startup_q[OBCD_UV_HI:OBCD_UV_LO]) != 2'h3))
      && (!uv_en_q || uv_lvl_q == $past(startup_q[OBCD_UV_HI:OBCD_UV_LO])))
    else $error("detector setting mismatch");
  AST_WDG_TYPE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(captured_q) |-> wdg_hw_q == !$past(startup_q[OBCD_WDG_TYPE]))
    else $error("watchdog type mismatch");
  AST_WDG_HALT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(captured_q) |-> wdg_halt_q == $past(startup_q[OBCD_WDG_HALT]))
    else $error("halt reset option mismatch");
  AST_SECTOR: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(captured_q) && $past(protect_q[OBCD_SEC_LO]) |-> sect_q == 2'h2)
    else $error("sector size mismatch");
  AST_READOUT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(captured_q) |-> (rd_blk_q == $past(protect_q[OBCD_READOUT])) && (rd_blk_q -> wr_blk_q))
    else $error("readout protection not applied");
  AST_ERASE_FIRST: assert property (@(posedge sys_clk) disable iff (!rst_b)
    erase_mem_first |=> erase_req_q && $stable(protect_q) && $stable(startup_q))
    else $error("bytes erased before memory");
  AST_WLOCK_FROZEN: assert property (@(posedge sys_clk) disable iff (!rst_b)
    protect_q[OBCD_WLOCK] |=> $stable(protect_q) && $stable(startup_q))
    else $error("locked option bytes changed");
  AST_PROG_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (rvalid_q && !$past(rvalid_q) && $past(ra_startup || ra_protect) && !$past(prog_mode))
      |-> rresp_q == 2'h2 && rdata_q == 32'h00000000)
    else $error("option byte read outside programming mode");
  AST_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    captured_q |=> $stable({clk_int_q, clk_wake_q, clk_ext_q, uv_en_q, uv_lvl_q, wdg_hw_q,
                            wdg_halt_q, sect_q, rd_blk_q, wr_blk_q}))
    else $error("captured settings changed before reset");

endmodule

`default_nettype wire

// *** testbench/obcd_mem_model.sv ***
// obcd_mem_model: program memory that answers erase requests
`timescale 1ns/10ps
`default_nettype none

module obcd_mem_model (
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic slow, // answer late when high
  input wire logic mem_erase_req, // erase request from decoder
  output logic mem_erase_done // one-cycle erase finished pulse
);
  int cnt;

  // count an erase out, then pulse done for one cycle
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      mem_erase_done <= 1'b0;
    end else begin
      mem_erase_done <= 1'b0;
      if (mem_erase_req && !mem_erase_done) begin
        cnt <= cnt + 1;
        if (cnt >= (slow ? 20 : 1)) begin
          mem_erase_done <= 1'b1;
          cnt <= 0;
        end
      end
    end
  end
endmodule

`default_nettype wire

// *** testbench/option_byte_config_decoder_bench.sv ***
// option_byte_config_decoder_bench: self-checking bench of the option byte decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t: got %h want %h", $time, a, b); end end

module option_byte_config_decoder_bench;
  import obcd_pkg::*;
  logic sys_clk = 1'b0, rst_b, prog_mode, slow, mem_erase_done, mem_erase_req;
  logic ci, cw, ce, uven, wdg, halt, rb, wb, refd;
  logic [1:0] lvl, sec, bresp, rresp;
  logic [7:0] awaddr, araddr, su, pr;
  logic [31:0] wdata, rdata, r;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] outs, held;
  int num_errors = 0, tests_run = 0, seed = 32'hede2;

  // decoded outputs gathered for comparison
  assign outs = {ci, cw, ce, uven, lvl, wdg, halt, sec, rb, wb};

  obcd_top obcd_top_inst (.sys_clk(sys_clk), .rst_b(rst_b), .prog_mode(prog_mode),
    .mem_erase_done(mem_erase_done), .mem_erase_req(mem_erase_req), .clk_sel_internal_rc(ci),
    .clk_sel_wakeup_rc(cw), .clk_sel_external(ce), .undervoltage_detector_en(uven),
    .undervoltage_level(lvl), .wdg_hw_enable(wdg), .wdg_halt_reset(halt), .sector_zero_size(sec),
    .flash_read_block(rb), .flash_write_block(wb), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  obcd_mem_model obcd_mem_model_inst (.sys_clk(sys_clk), .rst_b(rst_b), .slow(slow),
    .mem_erase_req(mem_erase_req), .mem_erase_done(mem_erase_done));

  // clock and watchdog
  always #4 sys_clk = ~sys_clk;
  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    close_out();
  end

  // ************************************************************
  // reference decode and bus tasks
  // ************************************************************
  function automatic logic [11:0] dec(input logic [7:0] s, input logic [7:0] p);
    logic [2:0] c;
    c = (s[7:6] == 2'h3) ? 3'b001 : (s[7:6] == 2'h1) ? 3'b010 : 3'b100;
    return {c, s[3:2] != 2'h3, (s[3:2] == 2'h3) ? 2'h0 : s[3:2], !s[1], s[0],
      p[2] ? 2'h2 : {1'b0, p[3]}, p[1], p[1] | p[0]};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] q;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge sys_clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      q = bresp;
      @(posedge sys_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
    `CHK(q, er)
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [33:0] q;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge sys_clk);
      ta = arvalid & arready;
      tr = rvalid;
      q = {rresp, rdata};
      @(posedge sys_clk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
    `CHK(q, {er, ed})
  endtask

  // option byte write through the model
  task automatic mwr(input logic [7:0] a, input logic [7:0] d);
    logic bad;
    bad = !prog_mode || pr[0];
    if (a == OBCD_ADDR_STARTUP && !bad) su = d;
    if (a == OBCD_ADDR_PROTECT && !bad) pr = d;
    refd = refd | bad;
    wr(a, {24'h0, d}, bad ? OBCD_RESP_SLVERR : OBCD_RESP_OKAY);
  endtask

  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    held = dec(su, pr); // bytes survive reset, capture sees them
    refd = 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic close_out;
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, prog_mode, slow} <= '0;
    {awaddr, araddr, wdata} <= '0;
    wstrb <= 4'h1;
    su = OBCD_STARTUP_DEFAULT;
    pr = OBCD_PROTECT_DEFAULT;
    do_reset();
    `CHK(outs, dec(su, pr))
    rd(OBCD_ADDR_STATUS, {28'h0, 1'b1, refd, 1'b0, prog_mode}, OBCD_RESP_OKAY);
    mwr(OBCD_ADDR_STARTUP, 8'hE3);
    rd(OBCD_ADDR_STATUS, {28'h0, 1'b1, refd, 1'b0, prog_mode}, OBCD_RESP_OKAY);
    wr(OBCD_ADDR_STATUS, 32'h4, OBCD_RESP_OKAY);
    rd(OBCD_ADDR_STARTUP, 32'h0, OBCD_RESP_SLVERR);
    refd = 1'b0;
    prog_mode <= 1'b1;
    @(posedge sys_clk);
    repeat (8) begin
      r = $random(seed);
      mwr(OBCD_ADDR_STARTUP, (r[7:0] & 8'hCF) | 8'h20);
      mwr(OBCD_ADDR_PROTECT, (r[15:8] | 8'hF0) & 8'hFE);
      rd(OBCD_ADDR_STARTUP, {24'h0, su}, OBCD_RESP_OKAY);
      rd(OBCD_ADDR_PROTECT, {24'h0, pr}, OBCD_RESP_OKAY);
      `CHK(outs, held)
      do_reset();
      `CHK(outs, dec(su, pr))
    end
    rd(8'h10, 32'h0, OBCD_RESP_DECERR);
    wr(8'h14, 32'h0, OBCD_RESP_DECERR);
    mwr(OBCD_ADDR_PROTECT, 8'hF0);
    wr(OBCD_ADDR_CTRL, 32'h1, OBCD_RESP_OKAY);
    su = OBCD_STARTUP_DEFAULT;
    rd(OBCD_ADDR_STARTUP, {24'h0, su}, OBCD_RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      slow <= k[0];
      mwr(OBCD_ADDR_STARTUP, 8'h6E);
      mwr(OBCD_ADDR_PROTECT, 8'hF2);
      wr(OBCD_ADDR_CTRL, 32'h1, OBCD_RESP_OKAY);
      `CHK(mem_erase_req, 1'b1)
      if (k == 1) rd(OBCD_ADDR_PROTECT, {24'h0, pr}, OBCD_RESP_OKAY);
      while (mem_erase_req) @(posedge sys_clk);
      su = OBCD_STARTUP_DEFAULT;
      pr = OBCD_PROTECT_DEFAULT;
      rd(OBCD_ADDR_STARTUP, {24'h0, su}, OBCD_RESP_OKAY);
      rd(OBCD_ADDR_PROTECT, {24'h0, pr}, OBCD_RESP_OKAY);
    end
    mwr(OBCD_ADDR_PROTECT, 8'hF1);
    mwr(OBCD_ADDR_STARTUP, 8'h2C);
    wr(OBCD_ADDR_CTRL, 32'h1, OBCD_RESP_SLVERR);
    rd(OBCD_ADDR_PROTECT, {24'h0, pr}, OBCD_RESP_OKAY);
    rd(OBCD_ADDR_STATUS, {28'h0, 1'b1, refd, 1'b0, prog_mode}, OBCD_RESP_OKAY);
    do_reset();
    `CHK(outs, dec(su, pr))
    rd(OBCD_ADDR_PROTECT, {24'h0, pr}, OBCD_RESP_OKAY);
    mwr(OBCD_ADDR_PROTECT, 8'hF0);
    rd(OBCD_ADDR_PROTECT, {24'h0, pr}, OBCD_RESP_OKAY);
    close_out();
  end
endmodule

`default_nettype wire
